// ### rtl/sct_pkg.sv
// Types shared by the single channel timer
package sct_pkg;
  typedef enum logic [2:0] {
    SCT_OC_FROZEN = 3'b000,
    SCT_OC_SET_MATCH = 3'b001,
    SCT_OC_CLR_MATCH = 3'b010,
    SCT_OC_TOGGLE = 3'b011,
    SCT_OC_FORCE_LOW = 3'b100,
    SCT_OC_FORCE_HIGH = 3'b101,
    SCT_OC_PWM1 = 3'b110,
    SCT_OC_PWM2 = 3'b111
  } sct_ocmode_type;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] dien;
    logic [15:0] sts;
    logic [15:0] ccm;
    logic [15:0] ccen;
    logic [15:0] opt;
    logic [15:0] cnt;
    logic [15:0] clock_prescaler;
    logic [15:0] psc_act;
    logic [15:0] psc_cnt;
    logic [15:0] arr;
    logic [15:0] arr_act;
    logic [15:0] cc1;
    logic [15:0] cc1_act;
    logic [1:0] dts_cnt;
    logic dts_tick;
    logic ref_lvl;
  } sct_state_type;
endpackage

// ### rtl/sct_regs.svh
// Register offsets, field positions and reset values of the timer
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH
`define SCT_OFF_CTRL 12'h000
`define SCT_OFF_DIEN 12'h00c
`define SCT_OFF_STS 12'h010
`define SCT_OFF_CEG 12'h014
`define SCT_OFF_CCM 12'h018
`define SCT_OFF_CCEN 12'h020
`define SCT_OFF_CNT 12'h024
`define SCT_OFF_PSC 12'h028
`define SCT_OFF_ARR 12'h02c
`define SCT_OFF_CC1 12'h034
`define SCT_OFF_OPT 12'h050
`define SCT_CTRL_MASK 16'h0387
`define SCT_DIEN_MASK 16'h0003
`define SCT_STS_MASK 16'h0003
`define SCT_CCM_MASK 16'h0073
`define SCT_CCEN_MASK 16'h0003
`define SCT_OPT_MASK 16'h0003
`define SCT_RST_VAL 16'h0000
`define SCT_RST_ARR 16'hffff
`define SCT_BIT_COUNTER_ENABLE 0
`define SCT_BIT_UD 1
`define SCT_BIT_URS 2
`define SCT_BIT_RELOAD_PRELOAD_ENABLE 7
`define SCT_BIT_UIF 0
`define SCT_BIT_CC1F 1
`define SCT_BIT_UG 0
`define SCT_BIT_CC1G 1
`define SCT_BIT_CCPOL 1
`endif

// ### rtl/sct_timer.sv
// Single channel timer with forced output, APB register file and interrupt
//
// How it works
// RULE1 - Forced mode ignores compare, drives forced level
// RULE2 - Direction select 00 makes channel an output
// RULE3 - Mode 100 forces inactive, 101 forces active
// RULE4 - Forced output still raises match flag, requests
// RULE5 - Sixteen bit registers at fixed offsets 0x00-0x50
// RULE6 - Counter enable bit 0 starts counting
// RULE7 - Update disable bit 1 blocks update events
// RULE8 - Update event loads reload, prescaler, compare
// RULE9 - Source select 1: only overflow raises update request
// RULE10 - Preload bit 7 defers reload writes to update
// RULE11 - Divide field 9:8 sets sampling period 1/2/4
// RULE12 - Enable bit 0 gates update interrupt
// RULE13 - Enable bit 1 gates channel one interrupt
// RULE14 - Control and enable registers reset to zero
// RULE15 - Hardware sets update flag, software writes zero
// RULE16 - Channel flag cleared by write or compare read
// RULE17 - Reserved bits and code read zero, ignored
`timescale 1ns/1ps
`include "sct_regs.svh"
module sct_timer
  import sct_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slave_update,
  input wire logic slave_trigger,
  input wire logic chan_in,
  output logic chan_out,
  output logic chan_out_en,
  output logic sampling_tick,
  output logic update_dma_req,
  output logic chan_dma_req,
  output logic irq
);
  sct_state_type s_reg;
  sct_state_type s_next;
  logic wr;
  logic rd;
  logic [15:0] wd;
  logic hit;
  logic cnt_tick;
  logic ovf;
  logic sw_ug;
  logic update_event;
  logic upd_req;
  logic match;
  logic cap_edge;
  logic chan_in_d;
  logic is_output;
  sct_ocmode_type ocm;
  logic [1:0] div_code;
  logic [31:0] rdata;

  // APB decode; zero wait states, registers ignore upper data
  assign wr = psel & penable & pwrite & clk_en;
  assign rd = psel & penable & ~pwrite & clk_en;
  assign wd = pwdata[15:0];
  assign pready = 1'b1;
  always_comb begin
    case (paddr) // RULE5
      `SCT_OFF_CTRL, `SCT_OFF_DIEN, `SCT_OFF_STS, `SCT_OFF_CEG,
      `SCT_OFF_CCM, `SCT_OFF_CCEN, `SCT_OFF_CNT, `SCT_OFF_PSC,
      `SCT_OFF_ARR, `SCT_OFF_CC1, `SCT_OFF_OPT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;
  // Read data is muxed from registers so it stands in the access cycle
  assign prdata = rdata;

  // Channel configuration decode
  assign is_output = (s_reg.ccm[1:0] == 2'b00); // RULE2
  assign ocm = sct_ocmode_type'(s_reg.ccm[6:4]);
  assign div_code = s_reg.ctrl[9:8];

  // Counter timing and event sources
  assign cnt_tick = s_reg.ctrl[`SCT_BIT_COUNTER_ENABLE]
                    & (s_reg.psc_cnt == s_reg.psc_act); // RULE6
  assign ovf = cnt_tick & (s_reg.cnt == s_reg.arr_act);
  assign sw_ug = wr & (paddr == `SCT_OFF_CEG) & pstrb[0] & wd[`SCT_BIT_UG];
  assign update_event = ~s_reg.ctrl[`SCT_BIT_UD]
               & (ovf | sw_ug | slave_update); // RULE7
  assign upd_req = update_event & (ovf | ~s_reg.ctrl[`SCT_BIT_URS]); // RULE9
  assign match = is_output & cnt_tick & (s_reg.cnt == s_reg.cc1_act);
  assign cap_edge = ~is_output & s_reg.ccen[0] & chan_in & ~chan_in_d;

  // Capture edge history register kept outside the struct for clarity
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_in_d <= 1'b0;
    end else if (clk_en) begin
      chan_in_d <= chan_in;
    end
  end

  // Next state of the whole timer
  always_comb begin
    s_next = s_reg;
    rdata = 32'h0000_0000;
    // Prescaler and counter
    if (s_reg.ctrl[`SCT_BIT_COUNTER_ENABLE]) begin
      s_next.psc_cnt = cnt_tick ? 16'h0000 : s_reg.psc_cnt + 16'h0001;
    end
    if (ovf) begin
      s_next.cnt = 16'h0000;
    end else if (cnt_tick) begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
    if (s_reg.ctrl[`SCT_BIT_COUNTER_ENABLE] == 1'b0 && slave_trigger) begin
      s_next.ctrl[`SCT_BIT_COUNTER_ENABLE] = 1'b1; // RULE6
    end
    // Sampling clock divider
    s_next.dts_tick = 1'b0;
    case (div_code) // RULE11
      2'b00: begin
        s_next.dts_cnt = 2'b00;
        s_next.dts_tick = 1'b1;
      end
      2'b01: begin
        s_next.dts_cnt = {1'b0, ~s_reg.dts_cnt[0]};
        s_next.dts_tick = s_reg.dts_cnt[0];
      end
      2'b10: begin
        s_next.dts_cnt = s_reg.dts_cnt + 2'b01;
        s_next.dts_tick = (s_reg.dts_cnt == 2'b11);
      end
      default: begin
        s_next.dts_cnt = 2'b00;
      end
    endcase
    // Reference level; forced modes ignore compare result
    if (is_output) begin
      case (ocm)
        SCT_OC_FROZEN: s_next.ref_lvl = s_reg.ref_lvl;
        SCT_OC_SET_MATCH: s_next.ref_lvl = match ? 1'b1 : s_reg.ref_lvl;
        SCT_OC_CLR_MATCH: s_next.ref_lvl = match ? 1'b0 : s_reg.ref_lvl;
        SCT_OC_TOGGLE: s_next.ref_lvl = s_reg.ref_lvl ^ match;
        SCT_OC_FORCE_LOW: s_next.ref_lvl = 1'b0; // RULE1 RULE3
        SCT_OC_FORCE_HIGH: s_next.ref_lvl = 1'b1; // RULE1 RULE3
        SCT_OC_PWM1: s_next.ref_lvl = s_next.cnt < s_reg.cc1_act;
        SCT_OC_PWM2: s_next.ref_lvl = !(s_next.cnt < s_reg.cc1_act);
        default: s_next.ref_lvl = 1'b0;
      endcase
    end
    // Update event loads active copies
    if (update_event) begin
      s_next.arr_act = s_reg.arr; // RULE8
      s_next.psc_act = s_reg.clock_prescaler; // RULE8
      s_next.cc1_act = s_reg.cc1; // RULE8
      if (sw_ug | slave_update) begin
        s_next.cnt = 16'h0000;
        s_next.psc_cnt = 16'h0000;
      end
    end
    if (cap_edge) begin
      s_next.cc1 = s_reg.cnt;
      s_next.cc1_act = s_reg.cnt;
    end
    // Register writes; reserved bits masked away
    if (wr) begin
      case (paddr)
        `SCT_OFF_CTRL: begin
          s_next.ctrl = wd & `SCT_CTRL_MASK; // RULE17
          if (wd[9:8] == 2'b11) begin
            s_next.ctrl[9:8] = s_reg.ctrl[9:8]; // RULE17
          end
        end
        `SCT_OFF_DIEN: s_next.dien = wd & `SCT_DIEN_MASK; // RULE13
        `SCT_OFF_STS: s_next.sts = s_reg.sts & wd & `SCT_STS_MASK; // RULE15
        `SCT_OFF_CCM: s_next.ccm = wd & `SCT_CCM_MASK;
        `SCT_OFF_CCEN: s_next.ccen = wd & `SCT_CCEN_MASK;
        `SCT_OFF_CNT: s_next.cnt = wd;
        `SCT_OFF_PSC: s_next.clock_prescaler = wd;
        `SCT_OFF_ARR: begin
          s_next.arr = wd;
          if (!s_reg.ctrl[`SCT_BIT_RELOAD_PRELOAD_ENABLE]) begin
            s_next.arr_act = wd; // RULE10
          end
        end
        `SCT_OFF_CC1: begin
          if (is_output) begin
            s_next.cc1 = wd;
            s_next.cc1_act = wd;
          end
        end
        `SCT_OFF_OPT: s_next.opt = wd & `SCT_OPT_MASK;
        default: s_next.opt = s_reg.opt;
      endcase
    end
    // Register reads
    if (rd) begin
      case (paddr)
        `SCT_OFF_CTRL: rdata = {16'h0000, s_reg.ctrl};
        `SCT_OFF_DIEN: rdata = {16'h0000, s_reg.dien};
        `SCT_OFF_STS: rdata = {16'h0000, s_reg.sts};
        `SCT_OFF_CCM: rdata = {16'h0000, s_reg.ccm};
        `SCT_OFF_CCEN: rdata = {16'h0000, s_reg.ccen};
        `SCT_OFF_CNT: rdata = {16'h0000, s_reg.cnt};
        `SCT_OFF_PSC: rdata = {16'h0000, s_reg.clock_prescaler};
        `SCT_OFF_ARR: rdata = {16'h0000, s_reg.arr};
        `SCT_OFF_CC1: begin
          rdata = {16'h0000, s_reg.cc1};
          s_next.sts[`SCT_BIT_CC1F] = 1'b0; // RULE16
        end
        `SCT_OFF_OPT: rdata = {16'h0000, s_reg.opt};
        default: rdata = 32'h0000_0000;
      endcase
    end
    // Hardware flag sets win over any clear
    if (upd_req) begin
      s_next.sts[`SCT_BIT_UIF] = 1'b1; // RULE15
    end
    if (match | cap_edge | (sw_ug & 1'b0)
        | (wr & (paddr == `SCT_OFF_CEG) & wd[`SCT_BIT_CC1G])) begin
      s_next.sts[`SCT_BIT_CC1F] = 1'b1; // RULE4 RULE16
    end
  end

  // State register; control and enable reset to zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0; // RULE14
      s_reg.arr <= `SCT_RST_ARR;
      s_reg.arr_act <= `SCT_RST_ARR;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // Outputs; channel polarity applied to the reference level
  assign chan_out = s_reg.ref_lvl ^ s_reg.ccen[`SCT_BIT_CCPOL];
  assign chan_out_en = is_output & s_reg.ccen[0]; // RULE2
  assign sampling_tick = s_reg.dts_tick;
  assign update_dma_req = upd_req & clk_en;
  assign chan_dma_req = (match | cap_edge) & clk_en; // RULE4
  assign irq = (s_reg.sts[`SCT_BIT_UIF] & s_reg.dien[0]) // RULE12
             | (s_reg.sts[`SCT_BIT_CC1F] & s_reg.dien[1]); // RULE13
endmodule

// ### sim/basic_timer_control_and_forced_output_bench.sv
// Self-checking bench for the single channel timer
`timescale 1ns/1ps
`include "sct_regs.svh"
module basic_timer_control_and_forced_output_bench;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic slave_update = 0, slave_trigger = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, chan_out, chan_out_en, tick, irq;
  int miscompares = 0, checks = 0, n;
  // Free running clock
  always #5 clk = ~clk;
  sct_timer u_dut (.clk(clk), .rstn(rstn), .clk_en(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slave_update(slave_update), .slave_trigger(slave_trigger),
    .chan_in(1'h0), .chan_out(chan_out), .chan_out_en(chan_out_en),
    .sampling_tick(tick), .update_dma_req(), .chan_dma_req(), .irq(irq));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  // One APB transfer; read data is taken at the edge that sees pready high
  task automatic xfer(logic wr, logic [11:0] a, logic [15:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    err = pslverr;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rdchk(string w, logic [11:0] a, logic [31:0] e);
    xfer(1'h0, a, 16'h0000);
    chk(w, e, rd);
  endtask
  task automatic t_reset;
    rdchk("ctrl", `SCT_OFF_CTRL, 32'h0000_0000);
    rdchk("dien", `SCT_OFF_DIEN, 32'h0000_0000);
    rdchk("reload", `SCT_OFF_ARR, 32'h0000_ffff);
    chk("irq", 32'h0, irq);
  endtask
  task automatic t_fields;
    xfer(1'h1, `SCT_OFF_CTRL, 16'hfe7e);
    rdchk("ctrl", `SCT_OFF_CTRL, 32'h0000_0206);
    xfer(1'h1, `SCT_OFF_CTRL, 16'h0306);
    rdchk("div", `SCT_OFF_CTRL, 32'h0000_0206);
    xfer(1'h1, `SCT_OFF_DIEN, 16'hffff);
    rdchk("dien", `SCT_OFF_DIEN, 32'h0000_0003);
    xfer(1'h0, 12'h004, 16'h0000);
    chk("slverr", 32'h1, err);
    xfer(1'h1, `SCT_OFF_DIEN, 16'h0000);
  endtask
  // Ticks over 16 cycles for divide codes 00, 01 and 10
  task automatic t_div;
    for (int c = 0; c < 3; c++) begin
      xfer(1'h1, `SCT_OFF_CTRL, 16'(c << 8));
      repeat (8) @(posedge clk);
      n = 0;
      repeat (16) begin
        @(posedge clk);
        n += tick;
      end
      chk("ticks", 16 >> c, n);
    end
  endtask
  task automatic t_force;
    xfer(1'h1, `SCT_OFF_CCM, 16'h0040);
    xfer(1'h1, `SCT_OFF_CCEN, 16'h0001);
    chk("oe", 32'h1, chan_out_en);
    chk("low", 32'h0, chan_out);
    xfer(1'h1, `SCT_OFF_ARR, 16'h0009);
    xfer(1'h1, `SCT_OFF_CC1, 16'h0004);
    xfer(1'h1, `SCT_OFF_CCM, 16'h0050);
    @(posedge clk);
    chk("high", 32'h1, chan_out);
    xfer(1'h1, `SCT_OFF_CTRL, 16'h0001);
    n = 0;
    repeat (30) begin
      @(posedge clk);
      n += chan_out;
    end
    chk("held", 30, n);
    xfer(1'h1, `SCT_OFF_CTRL, 16'h0000);
    rdchk("flags", `SCT_OFF_STS, 32'h0000_0003);
    xfer(1'h1, `SCT_OFF_STS, 16'h0002);
    rdchk("flags", `SCT_OFF_STS, 32'h0000_0002);
    xfer(1'h0, `SCT_OFF_CC1, 16'h0000);
    rdchk("flags", `SCT_OFF_STS, 32'h0000_0000);
    xfer(1'h1, `SCT_OFF_CCEN, 16'h0003);
    chk("inverted", 32'h0, chan_out);
  endtask
  task automatic t_irq;
    xfer(1'h1, `SCT_OFF_DIEN, 16'h0001);
    xfer(1'h1, `SCT_OFF_CEG, 16'h0001);
    rdchk("uflag", `SCT_OFF_STS, 32'h0000_0001);
    chk("irq on", 32'h1, irq);
    xfer(1'h1, `SCT_OFF_DIEN, 16'h0000);
    chk("irq off", 32'h0, irq);
    xfer(1'h1, `SCT_OFF_STS, 16'h0000);
    xfer(1'h1, `SCT_OFF_CTRL, 16'h0002);
    xfer(1'h1, `SCT_OFF_CEG, 16'h0001);
    rdchk("ud", `SCT_OFF_STS, 32'h0000_0000);
    xfer(1'h1, `SCT_OFF_CTRL, 16'h0004);
    xfer(1'h1, `SCT_OFF_CEG, 16'h0001);
    rdchk("urs", `SCT_OFF_STS, 32'h0000_0000);
    xfer(1'h1, `SCT_OFF_CTRL, 16'h0000);
    slave_update <= 1'h1;
    @(posedge clk);
    slave_update <= 1'h0;
    rdchk("slave", `SCT_OFF_STS, 32'h0000_0001);
    xfer(1'h1, `SCT_OFF_CEG, 16'h0002);
    xfer(1'h1, `SCT_OFF_DIEN, 16'h0002);
    chk("irq ch", 32'h1, irq);
    slave_trigger <= 1'h1;
    @(posedge clk);
    slave_trigger <= 1'h0;
    rdchk("trig", `SCT_OFF_CTRL, 32'h0000_0001);
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    t_reset;
    t_fields;
    t_div;
    t_force;
    t_irq;
    report_and_stop;
  end
  // Watchdog
  initial begin
    #100000;
    miscompares++;
    report_and_stop;
  end
endmodule

// ### sim/sct_checker.sv
// Port checker for the single channel timer
`timescale 1ns/1ps
`include "sct_regs.svh"
module sct_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic acc;
  logic map;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Access phase and address decode
  assign acc = psel && penable;
  assign map = paddr inside {`SCT_OFF_CTRL, `SCT_OFF_DIEN, `SCT_OFF_STS,
    `SCT_OFF_CEG, `SCT_OFF_CCM, `SCT_OFF_CCEN, `SCT_OFF_CNT, `SCT_OFF_PSC,
    `SCT_OFF_ARR, `SCT_OFF_CC1, `SCT_OFF_OPT};
  AST_ERR_ACC: assert property (pslverr |-> acc)
    else $error("error response outside access phase");
  AST_UNMAP: assert property (acc && !map |-> pslverr)
    else $error("unmapped address not refused");
  AST_MAP: assert property (acc && map |-> !pslverr)
    else $error("mapped address refused");
  AST_UPPER: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_IDLE: assert property (!(acc && !pwrite)
    |-> prdata == 32'h0000_0000)
    else $error("read data not cleared");
  AST_CTRL_RSV: assert property (acc && !pwrite && paddr == `SCT_OFF_CTRL
    |-> prdata[15:10] == 6'h00 && prdata[6:3] == 4'h0)
    else $error("control reserved bits set");
  AST_DIV: assert property (acc && !pwrite && paddr == `SCT_OFF_CTRL
    |-> prdata[9:8] != 2'h3)
    else $error("reserved divide code stored");
  AST_DIEN_RSV: assert property (acc && !pwrite && paddr == `SCT_OFF_DIEN
    |-> prdata[15:2] == 14'h0000)
    else $error("enable reserved bits set");
endmodule
bind sct_timer sct_checker u_chk (.clk(clk), .rstn(rstn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
